/* File: design/i2css_pkg.sv */
// Shared constants and types for the two-wire slave and soft master.
package i2css_pkg;
    // Register offsets of the device's own special-register port.
    localparam logic [7:0] I2CSS_ADDR_CTRL = 8'h0E;
    localparam logic [7:0] I2CSS_ADDR_DATA = 8'h09;
    localparam logic [7:0] I2CSS_ADDR_OWN = 8'h0D;
    localparam logic [7:0] I2CSS_ADDR_ENPRI = 8'hA9;
    localparam logic [7:0] I2CSS_ADDR_PRI = 8'hB8;
    // Control register bit positions.
    localparam int I2CSS_BIT_MDO = 7;
    localparam int I2CSS_BIT_MDE = 6;
    localparam int I2CSS_BIT_MCO = 5;
    localparam int I2CSS_BIT_MDI = 4;
    localparam int I2CSS_BIT_MODE = 3;
    localparam int I2CSS_BIT_RST = 2;
    localparam int I2CSS_BIT_DIR = 1;
    localparam int I2CSS_BIT_DONE = 0;
    // Enable/priority bit positions.
    localparam int I2CSS_BIT_ESI = 0;
    localparam int I2CSS_BIT_PSI_COMB = 4;
    localparam int I2CSS_BIT_PSI_OLD = 7;
    // Reset values, general call address and master-mode value.
    localparam logic [7:0] I2CSS_CTRL_RESET = 8'h00;
    localparam logic [7:0] I2CSS_BYTE_RESET = 8'h00;
    localparam logic [6:0] I2CSS_OWN_RESET = 7'h00;
    localparam logic [6:0] I2CSS_GENERAL_CALL = 7'h00;
    localparam logic [7:0] I2CSS_MASTER_INIT = 8'hA8;
    // Controller register offsets on AHB-Lite.
    localparam logic [7:0] I2CSS_AHB_CMD = 8'h00;
    localparam logic [7:0] I2CSS_AHB_STATUS = 8'h04;
    localparam logic [7:0] I2CSS_AHB_RXDATA = 8'h08;
    localparam logic [7:0] I2CSS_AHB_DIV = 8'h0C;
    localparam logic [15:0] I2CSS_DIV_RESET = 16'h0004;
    // Command codes.
    localparam logic [1:0] I2CSS_CMD_READ = 2'h1;
    localparam logic [1:0] I2CSS_CMD_WRITE = 2'h2;
    localparam logic [3:0] I2CSS_BITS_BYTE = 4'h8;
    typedef enum logic [2:0] {
        I2CSS_S_IDLE = 3'b000,
        I2CSS_S_ADDR = 3'b001,
        I2CSS_S_ACK = 3'b010,
        I2CSS_S_STRETCH = 3'b011,
        I2CSS_S_DATA = 3'b100,
        I2CSS_S_MACK = 3'b101
    } i2css_slave_state_type;
    typedef enum logic [3:0] {
        I2CSS_M_IDLE = 4'b0000,
        I2CSS_M_START = 4'b0001,
        I2CSS_M_BITLO = 4'b0010,
        I2CSS_M_BITHI = 4'b0011,
        I2CSS_M_ACKLO = 4'b0100,
        I2CSS_M_ACKHI = 4'b0101,
        I2CSS_M_STOPLO = 4'b0110,
        I2CSS_M_STOPHI = 4'b0111,
        I2CSS_M_STOPEND = 4'b1000
    } i2css_master_state_type;
endpackage

/* File: design/i2css_bus_if.sv */
// Two-wire bus joining the device end and the far end.
`timescale 1ns/1ps
interface i2css_bus_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic far_scl_o;
    logic far_scl_oe;
    logic far_sda_o;
    logic far_sda_oe;
    logic scl;
    logic sda;
    // Open drain with pull-up: a line is low while any enabled driver drives low.
    assign scl = ~((dev_scl_oe & ~dev_scl_o) | (far_scl_oe & ~far_scl_o));
    assign sda = ~((dev_sda_oe & ~dev_sda_o) | (far_sda_oe & ~far_sda_o));
    modport device (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
    modport far (output far_scl_o, far_scl_oe, far_sda_o, far_sda_oe, input scl, sda);
endinterface

/* File: design/i2css_device.sv */
// Device end: hardware slave plus bit-banged master register port.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// (R1) Ignore general call address, no ack.
// (R2) Repeated start restarts like fresh start.
// (R3) Direction bit changes only when differing.
// (R4) No start-byte support in slave.
// (R5) Only seven-bit addresses decoded.
// (R6) Stretch clock low until flag cleared.
// (R7) Master waits for clock release.
// (R8) Master mode has no clock readback.
// (R9) Data unreadable while master drives it.
// (R10) Losing master stops driving, waits free; the far master has no arbitration check and drives on regardless.
// (R11) Old variant: clear flag once explicitly.
// (R12) Data register access clears flag.
// (R13) Enable bit0, priority bit4 at A9h.
// (R14) Old variant: priority at B8h.
// (R15) Value A8h selects master, lines float.
// (R16) Master read sequence with final nack.
// (R17) Master write sequence with ack check.
// (R18) Address in upper seven bits.
// (R19) Stop before each new start.
// (R20) Flag after address and acked bytes.
// (R21) Stop, nack or reset returns idle.
module i2css_device
    import i2css_pkg::*;
#(
    parameter bit AUTO_CLEAR = 1'b1
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Special-register port.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Interrupt request towards the core.
    output logic serial_irq,
    output logic serial_irq_high_priority,
    // Bus.
    i2css_bus_if.device bus
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic [7:0] serial_ctrl_reg;
        logic [7:0] serial_byte_reg;
        logic [6:0] own_addr;
        logic [7:0] irq_enable_priority_reg;
        logic [7:0] irq_priority_reg;
        logic [7:0] shift;
        logic [3:0] bit_count;
        logic sda_low;
        logic scl_low;
        i2css_slave_state_type state;
        logic [7:0] sfr_rdata;
        logic serial_irq;
        logic serial_irq_high_priority;
        logic scl_o;
        logic sda_o;
        logic sda_oe;
    } i2css_dev_state_type;

    i2css_dev_state_type r;
    i2css_dev_state_type next_r;

    always_comb begin
        logic scl_s;
        logic sda_s;
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic master_mode;
        logic flag_clear;
        scl_s = r.scl_sync[1];
        sda_s = r.sda_sync[1];
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], bus.scl};
        next_r.sda_sync = {r.sda_sync[0], bus.sda};
        next_r.scl_prev = scl_s;
        next_r.sda_prev = sda_s;
        scl_rise = scl_s & ~r.scl_prev;
        scl_fall = ~scl_s & r.scl_prev;
        start_seen = scl_s & r.scl_prev & r.sda_prev & ~sda_s;
        stop_seen = scl_s & r.scl_prev & ~r.sda_prev & sda_s;
        master_mode = r.serial_ctrl_reg[I2CSS_BIT_MODE];
        flag_clear = 1'b0;
        // Register writes.
        if (sfr_wr) begin
            unique case (sfr_addr)
                I2CSS_ADDR_CTRL: begin
                    // Hardware owns the direction bit; software only sees it.
                    next_r.serial_ctrl_reg[7:2] = sfr_wdata[7:2];
                    if (!AUTO_CLEAR && !sfr_wdata[I2CSS_BIT_DONE]) begin
                        flag_clear = 1'b1; // [R11]
                    end
                end
                I2CSS_ADDR_DATA: begin
                    next_r.serial_byte_reg = sfr_wdata;
                    flag_clear = AUTO_CLEAR; // [R12]
                end
                I2CSS_ADDR_OWN: next_r.own_addr = sfr_wdata[6:0];
                I2CSS_ADDR_ENPRI: next_r.irq_enable_priority_reg = sfr_wdata; // [R13]
                I2CSS_ADDR_PRI: next_r.irq_priority_reg = sfr_wdata; // [R14]
                default: ;
            endcase
        end
        if (sfr_rd && sfr_addr == I2CSS_ADDR_DATA) begin
            flag_clear = flag_clear | AUTO_CLEAR; // [R12]
        end
        if (flag_clear) begin
            next_r.serial_ctrl_reg[I2CSS_BIT_DONE] = 1'b0;
        end
        unique case (sfr_addr)
            I2CSS_ADDR_CTRL: next_r.sfr_rdata = r.serial_ctrl_reg;
            I2CSS_ADDR_DATA: next_r.sfr_rdata = r.serial_byte_reg;
            I2CSS_ADDR_OWN: next_r.sfr_rdata = {1'b0, r.own_addr};
            I2CSS_ADDR_ENPRI: next_r.sfr_rdata = r.irq_enable_priority_reg;
            I2CSS_ADDR_PRI: next_r.sfr_rdata = r.irq_priority_reg;
            default: next_r.sfr_rdata = 8'h00;
        endcase
        if (master_mode) begin
            // Pins follow the control bits; no interrupt, no readback of SCL.
            next_r.state = I2CSS_S_IDLE;
            next_r.scl_o = r.serial_ctrl_reg[I2CSS_BIT_MCO]; // [R8] [R15]
            next_r.sda_o = r.serial_ctrl_reg[I2CSS_BIT_MDO];
            next_r.sda_oe = r.serial_ctrl_reg[I2CSS_BIT_MDE]; // [R15]
            // Data in latches on rising SCL only while the driver is off.
            if (scl_rise && !r.serial_ctrl_reg[I2CSS_BIT_MDE]) begin
                next_r.serial_ctrl_reg[I2CSS_BIT_MDI] = sda_s; // [R9]
            end
        end else begin
            next_r.scl_o = 1'b1;
            next_r.sda_o = 1'b0;
            next_r.sda_oe = r.sda_low;
            unique case (r.state)
                I2CSS_S_IDLE: next_r.sda_low = 1'b0;
                I2CSS_S_ADDR: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], sda_s};
                        next_r.bit_count = r.bit_count + 4'h1;
                    end
                    if (scl_fall && r.bit_count == I2CSS_BITS_BYTE) begin
                        // Only plain seven-bit, non-zero matches; no start byte or ten-bit.
                        if (r.shift[7:1] == r.own_addr && r.shift[7:1] != I2CSS_GENERAL_CALL) begin // [R1] [R4] [R5]
                            next_r.sda_low = 1'b1;
                            next_r.state = I2CSS_S_ACK;
                            next_r.serial_byte_reg = r.shift;
                            if (r.serial_ctrl_reg[I2CSS_BIT_DIR] != r.shift[0]) begin
                                next_r.serial_ctrl_reg[I2CSS_BIT_DIR] = r.shift[0]; // [R3]
                            end
                        end else begin
                            next_r.state = I2CSS_S_IDLE;
                        end
                    end
                end
                I2CSS_S_ACK: begin
                    // Ack bit clocked; flag and stretch on its falling edge.
                    if (scl_fall) begin
                        next_r.serial_ctrl_reg[I2CSS_BIT_DONE] = 1'b1; // [R20]
                        next_r.scl_low = 1'b1; // [R6]
                        next_r.sda_low = 1'b0;
                        next_r.state = I2CSS_S_STRETCH;
                    end
                end
                I2CSS_S_STRETCH: begin
                    if (!r.serial_ctrl_reg[I2CSS_BIT_DONE]) begin
                        next_r.bit_count = 4'h0;
                        next_r.shift = r.serial_byte_reg;
                        next_r.state = I2CSS_S_DATA;
                        next_r.sda_low = r.serial_ctrl_reg[I2CSS_BIT_DIR] & ~r.serial_byte_reg[7];
                    end
                end
                I2CSS_S_DATA: begin
                    // The first bit is on the line a cycle before the clock is let go, so no false start.
                    next_r.scl_low = 1'b0; // [R6]
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], sda_s};
                        next_r.bit_count = r.bit_count + 4'h1;
                    end
                    if (scl_fall) begin
                        if (r.bit_count == I2CSS_BITS_BYTE) begin
                            if (r.serial_ctrl_reg[I2CSS_BIT_DIR]) begin
                                next_r.sda_low = 1'b0;
                                next_r.state = I2CSS_S_MACK;
                            end else begin
                                next_r.serial_byte_reg = r.shift;
                                next_r.sda_low = 1'b1;
                                next_r.state = I2CSS_S_ACK;
                            end
                        end else if (r.serial_ctrl_reg[I2CSS_BIT_DIR]) begin
                            next_r.sda_low = ~r.shift[7];
                        end
                    end
                end
                I2CSS_S_MACK: begin
                    // The master's ack decides: nack ends the transfer.
                    if (scl_rise) begin
                        next_r.state = sda_s ? I2CSS_S_IDLE : I2CSS_S_ACK; // [R20] [R21]
                    end
                end
                default: next_r.state = I2CSS_S_IDLE;
            endcase
            // A start, repeated or not, begins address reception unless the reset bit is set in the same cycle.
            if (start_seen) begin
                next_r.state = I2CSS_S_ADDR; // [R2]
                next_r.bit_count = 4'h0;
                next_r.sda_low = 1'b0;
                next_r.scl_low = 1'b0;
            end
            if (stop_seen || r.serial_ctrl_reg[I2CSS_BIT_RST]) begin
                next_r.state = I2CSS_S_IDLE; // [R21]
                next_r.sda_low = 1'b0;
                next_r.scl_low = 1'b0;
                next_r.serial_ctrl_reg[I2CSS_BIT_RST] = 1'b0;
            end
        end
        next_r.serial_irq = r.serial_ctrl_reg[I2CSS_BIT_DONE] & ~master_mode
            & r.irq_enable_priority_reg[I2CSS_BIT_ESI];
        next_r.serial_irq_high_priority = AUTO_CLEAR ? r.irq_enable_priority_reg[I2CSS_BIT_PSI_COMB]
            : r.irq_priority_reg[I2CSS_BIT_PSI_OLD]; // [R13] [R14]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{scl_sync: 2'b11, sda_sync: 2'b11, scl_prev: 1'b1, sda_prev: 1'b1,
                serial_ctrl_reg: I2CSS_CTRL_RESET, serial_byte_reg: I2CSS_BYTE_RESET,
                own_addr: I2CSS_OWN_RESET, irq_enable_priority_reg: 8'h00, irq_priority_reg: 8'h00,
                shift: 8'h00, bit_count: 4'h0, sda_low: 1'b0, scl_low: 1'b0,
                state: I2CSS_S_IDLE, sfr_rdata: 8'h00, serial_irq: 1'b0,
                serial_irq_high_priority: 1'b0, scl_o: 1'b1, sda_o: 1'b0, sda_oe: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign sfr_rdata = r.sfr_rdata;
    assign serial_irq = r.serial_irq;
    assign serial_irq_high_priority = r.serial_irq_high_priority;
    // Open drain: the clock is driven only while low is wanted.
    assign bus.dev_scl_o = r.serial_ctrl_reg[I2CSS_BIT_MODE] ? r.scl_o : 1'b0;
    assign bus.dev_scl_oe = r.serial_ctrl_reg[I2CSS_BIT_MODE] ? ~r.scl_o : r.scl_low;
    assign bus.dev_sda_o = r.serial_ctrl_reg[I2CSS_BIT_MODE] ? r.sda_o : 1'b0;
    assign bus.dev_sda_oe = r.serial_ctrl_reg[I2CSS_BIT_MODE] ? (r.sda_oe & ~r.sda_o) : r.sda_low;
endmodule

/* File: design/i2css_far_master.sv */
// Far end: bus master that reads or writes one byte per command.
`timescale 1ns/1ps
module i2css_far_master
    import i2css_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Bus.
    i2css_bus_if.far bus
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [15:0] divider;
        logic [15:0] tick_count;
        logic [6:0] slave_addr;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic [7:0] shift;
        logic [3:0] bits_left;
        logic is_read;
        logic addr_phase;
        logic busy;
        logic error;
        logic done;
        logic scl_low;
        logic sda_low;
        i2css_master_state_type state;
        logic [31:0] hrdata;
    } i2css_far_state_type;

    i2css_far_state_type r;
    i2css_far_state_type next_r;

    always_comb begin
        logic tick;
        logic scl_s;
        logic sda_s;
        scl_s = r.scl_sync[1];
        sda_s = r.sda_sync[1];
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], bus.scl};
        next_r.sda_sync = {r.sda_sync[0], bus.sda};
        tick = (r.tick_count == 16'h0000);
        next_r.tick_count = tick ? r.divider : r.tick_count - 16'h0001;
        next_r.dp_wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_r.dp_wr = hwrite;
            next_r.dp_addr = haddr;
            unique case (haddr)
                I2CSS_AHB_STATUS: next_r.hrdata = {29'h0, r.error, r.done, r.busy};
                I2CSS_AHB_RXDATA: next_r.hrdata = {24'h0, r.rx_byte};
                I2CSS_AHB_DIV: next_r.hrdata = {16'h0, r.divider};
                default: next_r.hrdata = 32'h0000_0000;
            endcase
        end
        if (r.dp_wr) begin
            if (r.dp_addr == I2CSS_AHB_DIV) begin
                next_r.divider = hwdata[15:0];
            end
            // Command word: [1:0] kind, [14:8] slave address, [23:16] byte.
            if (r.dp_addr == I2CSS_AHB_CMD && !r.busy
                && (hwdata[1:0] == I2CSS_CMD_READ || hwdata[1:0] == I2CSS_CMD_WRITE)) begin
                next_r.is_read = (hwdata[1:0] == I2CSS_CMD_READ);
                next_r.slave_addr = hwdata[14:8];
                next_r.tx_byte = hwdata[23:16];
                next_r.busy = 1'b1;
                next_r.done = 1'b0;
                next_r.error = 1'b0;
                next_r.state = I2CSS_M_START;
            end
        end
        if (tick) begin
            unique case (r.state)
                I2CSS_M_IDLE: begin
                    next_r.scl_low = 1'b0;
                    next_r.sda_low = 1'b0;
                end
                I2CSS_M_START: begin
                    next_r.sda_low = 1'b1;
                    next_r.shift = {r.slave_addr, r.is_read}; // [R18]
                    next_r.bits_left = I2CSS_BITS_BYTE;
                    next_r.addr_phase = 1'b1;
                    next_r.state = I2CSS_M_BITLO;
                end
                I2CSS_M_BITLO: begin
                    next_r.scl_low = 1'b1;
                    if (!r.addr_phase && r.is_read) begin
                        next_r.sda_low = 1'b0;
                    end else begin
                        next_r.sda_low = ~r.shift[7];
                    end
                    next_r.state = I2CSS_M_BITHI;
                end
                I2CSS_M_BITHI: begin
                    // The slave may hold the clock low; wait for its release.
                    next_r.scl_low = 1'b0;
                    if (r.scl_low == 1'b0 && scl_s) begin // [R7]
                        next_r.shift = {r.shift[6:0], sda_s}; // [R16]
                        next_r.bits_left = r.bits_left - 4'h1;
                        next_r.state = (r.bits_left == 4'h1) ? I2CSS_M_ACKLO : I2CSS_M_BITLO;
                    end
                end
                I2CSS_M_ACKLO: begin
                    next_r.scl_low = 1'b1;
                    // A read ends with nack from us; else release for the slave's ack.
                    next_r.sda_low = 1'b0; // [R16]
                    next_r.state = I2CSS_M_ACKHI;
                end
                I2CSS_M_ACKHI: begin
                    next_r.scl_low = 1'b0;
                    if (r.scl_low == 1'b0 && scl_s) begin // [R7]
                        next_r.state = I2CSS_M_STOPLO;
                        if (!r.addr_phase && r.is_read) begin
                            next_r.rx_byte = r.shift; // [R16]
                        end else if (sda_s) begin
                            next_r.error = 1'b1; // [R16] [R17]
                        end else if (r.addr_phase) begin
                            next_r.addr_phase = 1'b0;
                            next_r.bits_left = I2CSS_BITS_BYTE;
                            next_r.shift = r.tx_byte; // [R17]
                            next_r.state = I2CSS_M_BITLO;
                        end
                    end
                end
                I2CSS_M_STOPLO: begin
                    next_r.scl_low = 1'b1;
                    next_r.sda_low = 1'b1;
                    next_r.state = I2CSS_M_STOPHI;
                end
                I2CSS_M_STOPHI: begin
                    next_r.scl_low = 1'b0;
                    if (r.scl_low == 1'b0 && scl_s) begin
                        next_r.state = I2CSS_M_STOPEND;
                    end
                end
                I2CSS_M_STOPEND: begin
                    // Every exchange closes with stop before the next start.
                    next_r.sda_low = 1'b0; // [R19]
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.state = I2CSS_M_IDLE;
                end
                default: next_r.state = I2CSS_M_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{scl_sync: 2'b11, sda_sync: 2'b11, dp_wr: 1'b0, dp_addr: 8'h00,
                divider: I2CSS_DIV_RESET, tick_count: 16'h0000, slave_addr: 7'h00, tx_byte: 8'h00,
                rx_byte: 8'h00, shift: 8'h00, bits_left: 4'h0, is_read: 1'b0, addr_phase: 1'b0,
                busy: 1'b0, error: 1'b0, done: 1'b0, scl_low: 1'b0, sda_low: 1'b0,
                state: I2CSS_M_IDLE, hrdata: 32'h0000_0000};
        end else begin
            r <= next_r;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus.far_scl_o = 1'b0;
    assign bus.far_scl_oe = r.scl_low;
    assign bus.far_sda_o = 1'b0;
    assign bus.far_sda_oe = r.sda_low;
endmodule

/* File: verif/i2css_assertions.sv */
// Checker of the two-wire bus between the device end and the far end.
`timescale 1ns/1ps
module i2css_assertions (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Line drivers of both ends and the resolved lines.
    input wire logic dev_scl_o,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic far_scl_o,
    input wire logic far_scl_oe,
    input wire logic far_sda_o,
    input wire logic far_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_far_scl_low; far_scl_oe |-> !far_scl_o; endproperty
    a_far_scl_low: assert property (p_far_scl_low) else $error("far clock driven high");
    property p_far_sda_low; far_sda_oe |-> !far_sda_o; endproperty
    a_far_sda_low: assert property (p_far_sda_low) else $error("far data driven high");
    // A start must be followed by clocking, or the bus hangs in a half-open frame.
    property p_start_clocked; $fell(sda) && scl && $past(scl) |-> ##[1:40] !scl; endproperty
    a_start_clocked: assert property (p_start_clocked) else $error("start without clock");
    property p_dev_sda_quiet; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
    a_dev_sda_quiet: assert property (p_dev_sda_quiet) else $error("slave data moved in clock high");
    property p_ack_low; $rose(dev_sda_oe) |-> !scl && !dev_sda_o; endproperty
    a_ack_low: assert property (p_ack_low) else $error("slave data driven outside clock low");
    property p_stretch_low; $rose(dev_scl_oe) && !dev_scl_o |-> $past(!scl); endproperty
    a_stretch_low: assert property (p_stretch_low) else $error("stretch began in clock high");
    property p_rise_free; dev_scl_oe && $past(dev_scl_oe) |-> $stable(far_sda_oe); endproperty
    a_rise_free: assert property (p_rise_free) else $error("far data moved while stretched");
    property p_stop_far; $rose(sda) && scl && $past(scl) |-> $past(far_sda_oe); endproperty
    a_stop_far: assert property (p_stop_far) else $error("stop not made by far end");
    c_stretch: cover property ($rose(dev_scl_oe) && !dev_scl_o);
    c_ack: cover property ($rose(dev_sda_oe));
    c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule

/* File: verif/i2c_slave_soft_master_tb_top.sv */
// Testbench joining the device end and the far end over the two-wire bus.
`timescale 1ns/1ps
module i2c_slave_soft_master_tb_top;
    import i2css_pkg::*;
    logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, hsel = 1, hwrite = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, haddr = 0, sfr_rdata, b;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 0, hrdata, q;
    logic serial_irq, serial_irq_high_priority, hreadyout, hresp;
    wire logic hready;
    int errors = 0, checks_done = 0;
    assign hready = hreadyout;
    always #50 ref_clk = ~ref_clk;
    i2css_bus_if bus ();
    i2css_device i2css_device_i (.*);
    i2css_far_master i2css_far_master_i (.*);
    i2css_assertions i2css_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n), .dev_scl_o(bus.dev_scl_o),
        .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
        .far_scl_o(bus.far_scl_o), .far_scl_oe(bus.far_scl_oe), .far_sda_o(bus.far_sda_o),
        .far_sda_oe(bus.far_sda_oe), .scl(bus.scl), .sda(bus.sda));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Access pulses last one cycle; rdata is taken one cycle after the address.
    task automatic sfr(logic wr, logic [7:0] a, logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= wr;
        sfr_rd <= !wr;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(posedge ref_clk);
        b = sfr_rdata;
    endtask
    task automatic wait_irq();
        // The irq output lags the flag by a cycle, so an old level is let go first.
        @(posedge ref_clk);
        for (int n = 0; n < 3000 && serial_irq !== 1'b1; n++) @(posedge ref_clk);
        chk("serial_irq", 1, serial_irq);
        chk("scl stretched", 0, bus.scl);
    endtask
    task automatic far_done();
        do ahb(1'b0, I2CSS_AHB_STATUS, 0); while (q[0] === 1'b1);
    endtask
    task automatic t_float();
        sfr(1'b1, I2CSS_ADDR_CTRL, I2CSS_MASTER_INIT);
        sfr(1'b0, I2CSS_ADDR_CTRL, 0);
        chk("ctrl", 8'hA8, b);
        chk("lines", 2'h3, {bus.scl, bus.sda});
        chk("sda_oe", 0, bus.dev_sda_oe);
        sfr(1'b1, I2CSS_ADDR_CTRL, 8'h00);
    endtask
    task automatic t_read();
        ahb(1'b1, I2CSS_AHB_CMD, {16'h0000, 8'h44, 6'h00, I2CSS_CMD_READ});
        wait_irq();
        sfr(1'b0, I2CSS_ADDR_CTRL, 0);
        chk("dir read", 1, b[I2CSS_BIT_DIR]);
        sfr(1'b1, I2CSS_ADDR_DATA, 8'h3C);
        far_done();
        chk("irq after nack", 0, serial_irq);
        chk("read error", 0, q[2]);
        ahb(1'b0, I2CSS_AHB_RXDATA, 0);
        chk("rx byte", 8'h3C, q[7:0]);
    endtask
    task automatic t_write();
        ahb(1'b1, I2CSS_AHB_CMD, {8'h00, 8'h5A, 8'h44, 6'h00, I2CSS_CMD_WRITE});
        wait_irq();
        sfr(1'b0, I2CSS_ADDR_CTRL, 0);
        chk("dir write", 0, b[I2CSS_BIT_DIR]);
        sfr(1'b0, I2CSS_ADDR_DATA, 0);
        chk("addr byte", 8'h88, b);
        wait_irq();
        sfr(1'b0, I2CSS_ADDR_DATA, 0);
        chk("data byte", 8'h5A, b);
        far_done();
        chk("write error", 0, q[2]);
    endtask
    task automatic t_refused(logic [7:0] a);
        ahb(1'b1, I2CSS_AHB_CMD, {8'h00, 8'h77, a, 6'h00, I2CSS_CMD_WRITE});
        far_done();
        chk("nack error", 1, q[2]);
        chk("no irq", 0, serial_irq);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        ahb(1'b1, I2CSS_AHB_DIV, 32'h0000_0007);
        sfr(1'b1, I2CSS_ADDR_OWN, 8'h44);
        sfr(1'b1, I2CSS_ADDR_ENPRI, 8'h11);
        @(posedge ref_clk);
        chk("irq priority", 1, serial_irq_high_priority);
        t_float();
        t_read();
        t_write();
        t_refused(8'h45);
        sfr(1'b1, I2CSS_ADDR_OWN, 8'h00);
        t_refused(8'h00);
        conclude();
    end
    // Whole run needs under 2000 cycles; twenty times that means a hang.
    initial begin
        #4000000;
        errors++;
        conclude();
    end
endmodule
